// ### inc/t2crc_regs.vh
// register map, field positions and constants of the timer block
`ifndef T2CRC_REGS_VH
`define T2CRC_REGS_VH
// register indices; byte address is four times the index
`define T2CRC_IDX_TIMER_CLOCK_DIVIDE_SELECT 8'h8e
`define T2CRC_IDX_IE 8'ha8
`define T2CRC_IDX_IP 8'hb8
`define T2CRC_IDX_CTRL 8'hc8
`define T2CRC_IDX_MODE 8'hc9
`define T2CRC_IDX_RCAPL 8'hca
`define T2CRC_IDX_RCAPH 8'hcb
`define T2CRC_IDX_CNTL 8'hcc
`define T2CRC_IDX_CNTH 8'hcd
`define T2CRC_IDX_ISTAT 8'hd0
`define T2CRC_IDX_ICLR 8'hd1
`define T2CRC_IDX_IEN 8'hd2
// control register fields
`define T2CRC_CTL_OVF 7
`define T2CRC_CTL_EXF 6
`define T2CRC_CTL_EXEN 3
`define T2CRC_CTL_RUN 2
`define T2CRC_CTL_CSEL 1
`define T2CRC_CTL_CAP 0
// mode register fields
`define T2CRC_MOD_OE 1
`define T2CRC_MOD_DOWN_COUNT_ENABLE 0
// divide select field
`define T2CRC_TMC_BYP 2
// interrupt enable / priority fields
`define T2CRC_IE_GLOBAL 7
`define T2CRC_IE_TIMER 5
`define T2CRC_IP_TIMER 5
// writable masks, reserved bits read zero
`define T2CRC_MASK_CTRL 8'hcf
`define T2CRC_MASK_MODE 8'h03
`define T2CRC_MASK_TIMER_CLOCK_DIVIDE_SELECT 8'h07
`define T2CRC_MASK_IE 8'hef
`define T2CRC_MASK_IP 8'h6f
// sticky status bits
`define T2CRC_ST_OVF 0
`define T2CRC_ST_EXT 1
`define T2CRC_NSTAT 2
// reset values
`define T2CRC_RST_BYTE 8'h00
`define T2CRC_RST_WORD 16'h0000
`define T2CRC_RST_STAT 2'h0
// counter constants
`define T2CRC_CNT_TOP 16'hffff
`define T2CRC_CNT_ONE 16'h0001
// prescale: divide by 12, counter runs 0..11
`define T2CRC_PRE_LAST 4'hb
`define T2CRC_PRE_ZERO 4'h0
`define T2CRC_PRE_ONE 4'h1
// pin synchroniser width
`define T2CRC_NPINS 2
`define T2CRC_PIN_CNT 0
`define T2CRC_PIN_TRIG 1
`endif

// ### core/t2crc_pin_sync.v
// two-stage synchroniser and falling-edge detect for the timer pins
`default_nettype none
`include "t2crc_regs.vh"
module t2crc_pin_sync (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // raw pins
  input wire [`T2CRC_NPINS-1:0] pinIn,
  // synchronised level and one-cycle falling pulse
  output wire [`T2CRC_NPINS-1:0] pinLevel,
  output wire [`T2CRC_NPINS-1:0] pinFall
);
  genvar i;
  generate
    for (i = 0; i < `T2CRC_NPINS; i = i + 1) begin : g_pin
      reg meta_q;
      reg sync_q;
      reg last_q;
      // pins idle high (pull-up), so reset to one to avoid a false edge
      always @(posedge clk_sys) begin
        if (!rst_b) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
          last_q <= 1'b1;
        end else begin
          meta_q <= pinIn[i];
          sync_q <= meta_q;
          last_q <= sync_q;
        end
      end
      assign pinLevel[i] = sync_q;
      assign pinFall[i] = last_q & ~sync_q;
    end
  endgenerate
endmodule
`default_nettype wire

// ### core/t2crc_top.v
// timer 2 counter with capture, reload, clock output and avalon registers
`default_nettype none
`include "t2crc_regs.vh"
module t2crc_top (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // avalon-mm slave
  input wire [9:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [3:0] avsByteEnable,
  input wire [31:0] avsWriteData,
  output wire [31:0] avsReadData,
  output wire avsWaitRequest,
  // serial port baud clock selects
  input wire serialTxClockSel,
  input wire serialRxClockSel,
  // pins
  input wire countPinIn,
  input wire externalTriggerPin,
  output wire countPinOut,
  output wire countPinOe,
  // interrupts
  output wire timerIrqReq,
  output wire timerIrqHighPri,
  output wire irqOut
);
  reg [7:0] tmconQ;
  reg [7:0] ieQ;
  reg [7:0] ipQ;
  reg [5:0] ctlQ;
  reg overflowFlagQ;
  reg externalEdgeFlagQ;
  reg [7:0] modeQ;
  reg [15:0] rcapQ;
  reg [15:0] cntQ;
  reg [3:0] preQ;
  reg halfQ;
  reg clkPinQ;
  reg [`T2CRC_NSTAT-1:0] statQ;
  reg [`T2CRC_NSTAT-1:0] statEnQ;
  reg ackQ;
  reg [7:0] rdataQ;
  reg [7:0] rdataD;
  reg [15:0] cntD;
  wire [`T2CRC_NPINS-1:0] pinLevel;
  wire [`T2CRC_NPINS-1:0] pinFall;

  // both pins come from outside and are synchronised first
  t2crc_pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pinIn({externalTriggerPin, countPinIn}),
    .pinLevel(pinLevel),
    .pinFall(pinFall)
  );

  // control fields
  wire exen = ctlQ[`T2CRC_CTL_EXEN];
  wire runCtl = ctlQ[`T2CRC_CTL_RUN];
  wire counterSel = ctlQ[`T2CRC_CTL_CSEL];
  wire captureSel = ctlQ[`T2CRC_CTL_CAP];
  wire clockOutEn = modeQ[`T2CRC_MOD_OE];
  wire downCountEn = modeQ[`T2CRC_MOD_DOWN_COUNT_ENABLE];
  wire prescaleBypass = tmconQ[`T2CRC_TMC_BYP];
  wire trigLevel = pinLevel[`T2CRC_PIN_TRIG];
  wire trigFall = pinFall[`T2CRC_PIN_TRIG];

  // bus decode: one wait cycle, access takes effect on the ack edge
  wire busReq = avsRead | avsWrite;
  wire busWr = avsWrite & ackQ & avsByteEnable[0];
  wire [7:0] regIdx = avsAddress[9:2];
  wire [7:0] wdata = avsWriteData[7:0];
  wire wrTmcon = busWr & (regIdx == `T2CRC_IDX_TIMER_CLOCK_DIVIDE_SELECT);
  wire wrIe = busWr & (regIdx == `T2CRC_IDX_IE);
  wire wrIp = busWr & (regIdx == `T2CRC_IDX_IP);
  wire wrCtl = busWr & (regIdx == `T2CRC_IDX_CTRL);
  wire wrMode = busWr & (regIdx == `T2CRC_IDX_MODE);
  wire wrRcapL = busWr & (regIdx == `T2CRC_IDX_RCAPL);
  wire wrRcapH = busWr & (regIdx == `T2CRC_IDX_RCAPH);
  wire wrCntL = busWr & (regIdx == `T2CRC_IDX_CNTL);
  wire wrCntH = busWr & (regIdx == `T2CRC_IDX_CNTH);
  wire wrIclr = busWr & (regIdx == `T2CRC_IDX_ICLR);
  wire wrIen = busWr & (regIdx == `T2CRC_IDX_IEN);

  // mode decode
  wire baudMode = serialTxClockSel | serialRxClockSel;
  wire clkOutMode = clockOutEn & ~counterSel;
  wire dcMode = downCountEn & ~captureSel & ~clkOutMode;
  wire countDown = dcMode & ~trigLevel;

  // prescaler: tick every 12th cycle unless bypassed
  wire preTick = prescaleBypass | (preQ == `T2CRC_PRE_LAST);
  // timer or counter source
  wire srcTick = counterSel ? pinFall[`T2CRC_PIN_CNT] : preTick;
  // clock-out halves the rate again to reach the divide by four
  wire tick = runCtl & srcTick & (~clkOutMode | halfQ);

  // overflow and underflow events
  wire atTop = (cntQ == `T2CRC_CNT_TOP);
  wire overUp = tick & ~countDown & atTop;
  wire underDn = tick & countDown & (cntQ == rcapQ);
  wire ovf = overUp | underDn;

  // trigger events; down-count mode takes the pin as direction instead
  wire extEvent = exen & trigFall & ~dcMode;
  wire trigAct = extEvent & ~baudMode & ~clkOutMode;
  wire capEdge = trigAct & captureSel;
  wire reloadEdge = trigAct & ~captureSel;
  wire reloadOvf = overUp & (~captureSel | clkOutMode);

  // flag set terms
  wire setOvf = ovf & ~baudMode & ~clkOutMode;
  wire toggleExf = dcMode & ovf;

  // prescaler and clock-out half-rate state
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      preQ <= `T2CRC_PRE_ZERO;
      halfQ <= 1'b0;
    end else begin
      if (preTick)
        preQ <= `T2CRC_PRE_ZERO;
      else
        preQ <= preQ + `T2CRC_PRE_ONE;
      if (runCtl & srcTick & clkOutMode)
        halfQ <= ~halfQ;
    end
  end

  // next count: software write wins, then reload, then counting
  always @* begin
    cntD = cntQ;
    if (wrCntL | wrCntH) begin
      if (wrCntL)
        cntD[7:0] = wdata;
      if (wrCntH)
        cntD[15:8] = wdata;
    end else if (reloadEdge | reloadOvf) begin
      cntD = rcapQ;
    end else if (underDn) begin
      cntD = `T2CRC_CNT_TOP;
    end else if (tick) begin
      if (countDown)
        cntD = cntQ - `T2CRC_CNT_ONE;
      else
        cntD = cntQ + `T2CRC_CNT_ONE;
    end
  end

  // counter, capture/reload register and clock output pin
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cntQ <= `T2CRC_RST_WORD;
      rcapQ <= `T2CRC_RST_WORD;
      clkPinQ <= 1'b0;
    end else begin
      cntQ <= cntD;
      if (capEdge) begin
        rcapQ <= cntQ;
      end else begin
        if (wrRcapL)
          rcapQ[7:0] <= wdata;
        if (wrRcapH)
          rcapQ[15:8] <= wdata;
      end
      if (overUp & clkOutMode)
        clkPinQ <= ~clkPinQ;
    end
  end

  // configuration registers; reserved bits are masked off
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      tmconQ <= `T2CRC_RST_BYTE;
      ieQ <= `T2CRC_RST_BYTE;
      ipQ <= `T2CRC_RST_BYTE;
      ctlQ <= 6'h00;
      modeQ <= `T2CRC_RST_BYTE;
    end else begin
      if (wrTmcon)
        tmconQ <= wdata & `T2CRC_MASK_TIMER_CLOCK_DIVIDE_SELECT;
      if (wrIe)
        ieQ <= wdata & `T2CRC_MASK_IE;
      if (wrIp)
        ipQ <= wdata & `T2CRC_MASK_IP;
      if (wrCtl)
        ctlQ <= {2'h0, wdata[3:0]};
      if (wrMode)
        modeQ <= wdata & `T2CRC_MASK_MODE;
    end
  end

  // hardware flags: a hardware set beats a software clear in one cycle
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      overflowFlagQ <= 1'b0;
      externalEdgeFlagQ <= 1'b0;
    end else begin
      if (setOvf)
        overflowFlagQ <= 1'b1;
      else if (wrCtl)
        overflowFlagQ <= wdata[`T2CRC_CTL_OVF];
      if (toggleExf)
        externalEdgeFlagQ <= ~externalEdgeFlagQ;
      else if (extEvent)
        externalEdgeFlagQ <= 1'b1;
      else if (wrCtl)
        externalEdgeFlagQ <= wdata[`T2CRC_CTL_EXF];
    end
  end

  // sticky event status, write-one-to-clear; a new event wins the clear
  genvar s;
  generate
    for (s = 0; s < `T2CRC_NSTAT; s = s + 1) begin : g_stat
      wire evt = (s == `T2CRC_ST_OVF) ? setOvf : extEvent;
      always @(posedge clk_sys) begin
        if (!rst_b)
          statQ[s] <= 1'b0;
        else if (evt)
          statQ[s] <= 1'b1;
        else if (wrIclr & wdata[s])
          statQ[s] <= 1'b0;
      end
    end
  endgenerate

  // status enable register
  always @(posedge clk_sys) begin
    if (!rst_b)
      statEnQ <= `T2CRC_RST_STAT;
    else if (wrIen)
      statEnQ <= wdata[`T2CRC_NSTAT-1:0];
  end

  // read mux; the value is latched during the wait cycle
  always @* begin
    case (regIdx)
      `T2CRC_IDX_TIMER_CLOCK_DIVIDE_SELECT: rdataD = tmconQ;
      `T2CRC_IDX_IE: rdataD = ieQ;
      `T2CRC_IDX_IP: rdataD = ipQ;
      `T2CRC_IDX_CTRL:
        rdataD = {overflowFlagQ, externalEdgeFlagQ, ctlQ};
      `T2CRC_IDX_MODE: rdataD = modeQ;
      `T2CRC_IDX_RCAPL: rdataD = rcapQ[7:0];
      `T2CRC_IDX_RCAPH: rdataD = rcapQ[15:8];
      `T2CRC_IDX_CNTL: rdataD = cntQ[7:0];
      `T2CRC_IDX_CNTH: rdataD = cntQ[15:8];
      `T2CRC_IDX_ISTAT: rdataD = {6'h00, statQ};
      `T2CRC_IDX_IEN: rdataD = {6'h00, statEnQ};
      default: rdataD = `T2CRC_RST_BYTE;
    endcase
  end

  // bus handshake: every access waits exactly one cycle
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ackQ <= 1'b0;
      rdataQ <= `T2CRC_RST_BYTE;
    end else begin
      ackQ <= busReq & ~ackQ;
      if (avsRead & ~ackQ)
        rdataQ <= rdataD;
    end
  end

  assign avsWaitRequest = busReq & ~ackQ;
  assign avsReadData = {24'h000000, rdataQ};

  // pin drive only in clock-output mode, otherwise pin is an input
  assign countPinOe = clkOutMode;
  assign countPinOut = clkPinQ;

  // in down-count mode the external flag is a 17th bit, not an interrupt
  assign timerIrqReq = ieQ[`T2CRC_IE_GLOBAL] & ieQ[`T2CRC_IE_TIMER]
    & (overflowFlagQ | (externalEdgeFlagQ & ~dcMode));
  assign timerIrqHighPri = ipQ[`T2CRC_IP_TIMER];
  assign irqOut = |(statQ & statEnQ);
endmodule
`default_nettype wire

// ### verif/t2crc_checker.sv
// port-level assertions for the timer block
`default_nettype none
`include "t2crc_regs.vh"
module t2crc_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register bus
  input wire logic [9:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  // pins and interrupts
  input wire logic countPinOe,
  input wire logic timerIrqReq,
  input wire logic timerIrqHighPri,
  input wire logic irqOut
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [7:0] ieQ, ipQ, ctlQ, modQ, ienQ;
  wire req = avsRead || avsWrite;
  wire [7:0] wd = avsWriteData[7:0];
  // shadow control bytes on the accepting edge; bench keeps byteenable
  // high for these, so it need not be watched here
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      {ieQ, ipQ, ctlQ, modQ, ienQ} <= 40'h0;
    end else if (avsWrite && !avsWaitRequest) begin
      case (avsAddress[9:2])
        `T2CRC_IDX_IE: ieQ <= wd;
        `T2CRC_IDX_IP: ipQ <= wd;
        `T2CRC_IDX_CTRL: ctlQ <= wd;
        `T2CRC_IDX_MODE: modQ <= wd;
        `T2CRC_IDX_IEN: ienQ <= wd;
        default: ;
      endcase
    end
  end
  // a request is held off one cycle, then answered
  sequence reqWait;
    req && avsWaitRequest;
  endsequence
  sequence reqAck;
    req && !avsWaitRequest;
  endsequence
  chk_wait_first: assert property ($rose(req) |-> reqWait)
    else $error("request not held off in first cycle");
  chk_wait_once: assert property (reqWait |=> reqAck)
    else $error("request not answered after one wait");
  chk_wait_idle: assert property (!req |-> !avsWaitRequest)
    else $error("wait raised with no request");
  chk_rdata_hold: assert property (!avsRead |=> $stable(avsReadData))
    else $error("read data moved without a read");
  chk_irq_gate: assert property (
    !(ieQ[7] && ieQ[5]) && $stable(ieQ) |-> !timerIrqReq)
    else $error("timer request while disabled");
  chk_pri_follow: assert property (
    $stable(ipQ) |-> timerIrqHighPri == ipQ[5])
    else $error("priority output differs from setting");
  chk_oe_mode: assert property (
    $stable(modQ) && $stable(ctlQ) |-> countPinOe == (modQ[1] && !ctlQ[1]))
    else $error("count pin enable wrong for mode");
  chk_irq_mask: assert property (
    ienQ[1:0] == 2'b00 && $stable(ienQ) |-> !irqOut)
    else $error("interrupt out while all masked");
endmodule
bind t2crc_top t2crc_checker chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsWriteData(avsWriteData), .avsReadData(avsReadData),
  .avsWaitRequest(avsWaitRequest), .countPinOe(countPinOe),
  .timerIrqReq(timerIrqReq), .timerIrqHighPri(timerIrqHighPri),
  .irqOut(irqOut));
`default_nettype wire

// ### verif/t2crc_pin_model.sv
// far-side model: count pulse source and trigger line with pull-up
`default_nettype none
module t2crc_pin_model (
  // clock
  input wire logic clk_sys,
  // pin drives
  output var logic countDrv,
  output var logic trigDrv
);
  timeunit 1ns;
  timeprecision 1ns;
  // both rest high; the trigger has a pull-up
  initial begin
    countDrv = 1'b1;
    trigDrv = 1'b1;
  end
  // hold each level 4 clocks so the 2-stage synchroniser sees it
  task automatic pulse(input bit trig, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (trig) trigDrv <= 1'b0;
      else countDrv <= 1'b0;
      repeat (4) @(posedge clk_sys);
      trigDrv <= 1'b1;
      countDrv <= 1'b1;
      repeat (4) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// ### verif/test_timer2_capture_reload_control.sv
// self-checking bench for the timer block
`default_nettype none
module test_timer2_capture_reload_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_b, avsRead, avsWrite, serialRxClockSel;
  logic [9:0] avsAddress;
  logic [3:0] avsByteEnable;
  logic [31:0] avsWriteData;
  logic [7:0] q;
  logic [3:0] be = 4'h1;
  wire [31:0] avsReadData;
  wire avsWaitRequest, countPinOut, countPinOe, countDrv, trigDrv;
  wire timerIrqReq, timerIrqHighPri, irqOut;
  // count pin level: timer drives it only while enabled
  wire countWire = countPinOe ? countPinOut : countDrv;
  int badCount = 0;
  int nTests = 0;
  int toggles;
  logic [7:0] rstIdx [11] = '{8'h8e, 8'ha8, 8'hb8, 8'hc8, 8'hc9, 8'hca,
    8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'hd2};
  logic [7:0] rwIdx [4] = '{8'h8e, 8'hc9, 8'ha8, 8'hb8};
  logic [7:0] rwMask [4] = '{8'h07, 8'h03, 8'hef, 8'h6f};
  t2crc_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsByteEnable(avsByteEnable),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .serialTxClockSel(1'b0),
    .serialRxClockSel(serialRxClockSel), .countPinIn(countWire),
    .externalTriggerPin(trigDrv), .countPinOut(countPinOut),
    .countPinOe(countPinOe), .timerIrqReq(timerIrqReq),
    .timerIrqHighPri(timerIrqHighPri), .irqOut(irqOut));
  t2crc_pin_model pins (.clk_sys(clk_sys), .countDrv(countDrv),
    .trigDrv(trigDrv));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic results();
    $display("comparisons %0d, mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one access: the request stands until the edge that sees waitrequest
  // low, data is taken at that edge, then a falling edge lets outputs settle
  task automatic bus(input bit rd, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    avsAddress <= {idx, 2'b00};
    avsByteEnable <= be;
    avsRead <= rd;
    avsWrite <= !rd;
    avsWriteData <= {24'h0, d};
    do @(posedge clk_sys); while (avsWaitRequest !== 1'b0);
    q = avsReadData[7:0];
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b0, idx, d);
  endtask
  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b1, idx, 8'h00);
    check(q, exp);
  endtask
  // hang guard, far beyond the fewer than a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    badCount++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    results();
  end
  initial begin
    {rst_b, avsRead, avsWrite, serialRxClockSel} = 4'h0;
    avsAddress = 10'h000;
    avsWriteData = 32'h0;
    avsByteEnable = 4'h1;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (rstIdx[i]) rdChk(rstIdx[i], 8'h00);
    foreach (rwIdx[i]) begin
      wr(rwIdx[i], 8'hff);
      rdChk(rwIdx[i], rwMask[i]);
      wr(rwIdx[i], 8'h00);
    end
    wr(8'hc8, 8'hf0);
    rdChk(8'hc8, 8'hc0);
    wr(8'hc8, 8'h00);
    rdChk(8'hc8, 8'h00);
    wr(8'h10, 8'hff);
    rdChk(8'h10, 8'h00);
    be = 4'he;
    wr(8'hca, 8'h55);
    be = 4'h1;
    rdChk(8'hca, 8'h00);
    // undivided clock: run stays on for three edges, the stop write's own
    // two-cycle access included
    wr(8'h8e, 8'h04);
    wr(8'hc8, 8'h04);
    wr(8'hc8, 8'h00);
    rdChk(8'hcc, 8'h03);
    rdChk(8'hcc, 8'h03);
    // divide by 12 over about 243 cycles; prescaler phase is free
    wr(8'hcc, 8'h00);
    wr(8'h8e, 8'h00);
    wr(8'hc8, 8'h04);
    repeat (240) @(posedge clk_sys);
    wr(8'hc8, 8'h00);
    bus(1'b1, 8'hcc, 8'h00);
    check({7'h0, q inside {8'd20, 8'd21}}, 8'h01);
    // reload from near the top, first as baud clock, then as plain timer
    wr(8'h8e, 8'h04);
    wr(8'hca, 8'hf0);
    wr(8'hcb, 8'hff);
    for (int b = 1; b >= 0; b--) begin
      @(posedge clk_sys);
      serialRxClockSel <= b[0];
      wr(8'hcc, 8'hfe);
      wr(8'hcd, 8'hff);
      wr(8'hc8, 8'h04);
      repeat (4) @(posedge clk_sys);
      rdChk(8'hc8, b ? 8'h04 : 8'h84);
      // stop without writing a zero over the flag just set
      wr(8'hc8, b ? 8'h00 : 8'h80);
    end
    // ten ticks from 0xfffe: wrap reloads 0xfff0, then eight more
    rdChk(8'hcd, 8'hff);
    rdChk(8'hcc, 8'hf8);
    rdChk(8'hd0, 8'h01);
    check({7'h0, irqOut}, 8'h00);
    wr(8'hd2, 8'h01);
    check({7'h0, irqOut}, 8'h01);
    wr(8'hd1, 8'h01);
    check({7'h0, irqOut}, 8'h00);
    rdChk(8'hd0, 8'h00);
    wr(8'ha8, 8'h20);
    check({7'h0, timerIrqReq}, 8'h00);
    wr(8'ha8, 8'ha0);
    check({7'h0, timerIrqReq}, 8'h01);
    wr(8'ha8, 8'h00);
    wr(8'hb8, 8'h20);
    check({7'h0, timerIrqHighPri}, 8'h01);
    wr(8'hb8, 8'h00);
    rdChk(8'hc8, 8'h80);
    // capture: edge ignored without edge enable, taken with it
    wr(8'hcc, 8'h34);
    wr(8'hcd, 8'h12);
    wr(8'hc8, 8'h01);
    pins.pulse(1'b1, 1);
    rdChk(8'hc8, 8'h01);
    rdChk(8'hca, 8'hf0);
    wr(8'hc8, 8'h09);
    pins.pulse(1'b1, 1);
    rdChk(8'hc8, 8'h49);
    rdChk(8'hca, 8'h34);
    rdChk(8'hcb, 8'h12);
    wr(8'hc8, 8'h08);
    rdChk(8'hc8, 8'h08);
    // counter mode counts falling edges on the count pin
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h06);
    pins.pulse(1'b0, 3);
    wr(8'hc8, 8'h00);
    rdChk(8'hcc, 8'h03);
    // clock out with reload 0xfffe: toggle every 4 cycles; capture left
    // 0x12 in the high byte, so reload and count are set in full
    wr(8'hca, 8'hfe);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    wr(8'hc9, 8'h02);
    check({7'h0, countPinOe}, 8'h01);
    wr(8'hc8, 8'h04);
    repeat (8) @(negedge clk_sys);
    toggles = 0;
    for (int k = 0; k < 16; k++) begin
      q[0] = countPinOut;
      @(negedge clk_sys);
      toggles += int'(countPinOut !== q[0]);
    end
    check(8'(toggles), 8'h04);
    wr(8'hc8, 8'h00);
    rdChk(8'hc8, 8'h00);
    wr(8'hc9, 8'h00);
    check({7'h0, countPinOe}, 8'h00);
    results();
  end
endmodule
`default_nettype wire
